//--- ert_defs.svh
`ifndef ERT_DEFS_SVH
`define ERT_DEFS_SVH

// ************************************************************
// Register byte offsets.
// ************************************************************
`define ERT_OFF_LINES 8'h00
`define ERT_OFF_ST_BITS 8'h04
`define ERT_OFF_TURNS 8'h08
`define ERT_OFF_DIVIDER 8'h0c
`define ERT_OFF_CONFIG 8'h10
`define ERT_OFF_POLES 8'h14
`define ERT_OFF_STATUS 8'h18
`define ERT_OFF_QUOTIENT 8'h1c
`define ERT_OFF_SC_RES 8'h20
`define ERT_OFF_POS_LO 8'h24
`define ERT_OFF_POS_HI 8'h28
`define ERT_OFF_TURNS_EFF 8'h2c

// ************************************************************
// Reset values.
// ************************************************************
`define ERT_RST_LINES 16'h1000
`define ERT_RST_ST_BITS 6'h00
`define ERT_RST_TURNS 8'h10
`define ERT_RST_DIVIDER 16'h0001
`define ERT_RST_POLES 8'h02

// ************************************************************
// Field positions and fixed figures.
// ************************************************************
`define ERT_CFG_LINEAR_BIT 8
`define ERT_CFG_FILTER_BIT 7
`define ERT_STAT_TRIP_BIT 0
`define ERT_STAT_CODE_LSB 8
`define ERT_QUOT_BUSY_BIT 16
`define ERT_MAX_TURNS 8'h10
`define ERT_TRIP_INIT_FAILED 4'h7
`define ERT_DIV_STEPS 5'h10

`endif

//--- ert_pkg.sv
package ert_pkg;

  typedef enum logic [3:0] {
    ERT_QUADRATURE_INCREMENTAL = 4'h0,
    ERT_FREQUENCY_DIRECTION_INCREMENTAL = 4'h1,
    ERT_FORWARD_REVERSE_INCREMENTAL = 4'h2,
    ERT_SINE_COSINE_INCREMENTAL = 4'h3,
    ERT_SINE_COSINE_WITH_SYNCHRONOUS_SERIAL = 4'h4,
    ERT_SERIAL_ONLY = 4'h5
  } ert_enc_type_t;

  typedef enum logic [1:0] {
    ERT_DIV_IDLE = 2'b00,
    ERT_DIV_RUN = 2'b01,
    ERT_DIV_DONE = 2'b11
  } ert_div_state_t;

  typedef struct packed {
    logic linear;
    logic filter;
    ert_enc_type_t enc_type;
  } ert_cfg_t;

  typedef struct packed {
    logic write;
    logic [7:0] addr;
  } ert_bus_req_t;

endpackage : ert_pkg

//--- ert_encoder_setup.sv
// Local design decisions: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`include "ert_defs.svh"

module ert_encoder_setup #(
  parameter int INTERP_BITS = 10
) (
  input wire logic CLK_IN,
  input wire logic RESETN_IN,
  input wire logic HSEL_IN,
  input wire logic [31:0] HADDR_IN,
  input wire logic [1:0] HTRANS_IN,
  input wire logic HWRITE_IN,
  input wire logic [2:0] HSIZE_IN,
  input wire logic [31:0] HWDATA_IN,
  input wire logic HREADY_IN,
  output logic [31:0] HRDATA_OUT,
  output logic HREADYOUT_OUT,
  output logic HRESP_OUT,
  input wire logic ENC_A_IN,
  input wire logic ENC_B_IN,
  input wire logic COMMS_VALID_IN,
  input wire logic [47:0] COMMS_DATA_IN,
  input wire logic AUTO_TURNS_VALID_IN,
  input wire logic [7:0] AUTO_TURNS_IN,
  output logic [47:0] POSITION_OUT,
  output logic TRIP_OUT,
  output logic [3:0] TRIP_CODE_OUT
);

  // ************************************************************
  // Helper functions.
  // ************************************************************
  function automatic logic [4:0] eff_turns(input logic [7:0] t);
    eff_turns = (t > `ERT_MAX_TURNS) ? 5'h10 : t[4:0];
  endfunction : eff_turns

  function automatic logic [15:0] turns_mask(input logic [4:0] n);
    turns_mask = 16'((17'h00001 << n) - 17'h00001);
  endfunction : turns_mask

  function automatic logic is_serial(input ert_pkg::ert_enc_type_t t);
    is_serial = (t == ert_pkg::ERT_SINE_COSINE_WITH_SYNCHRONOUS_SERIAL) ||
      (t == ert_pkg::ERT_SERIAL_ONLY);
  endfunction : is_serial

  // ************************************************************
  // Registers and state.
  // ************************************************************
  logic [15:0] lines;
  logic [5:0] st_bits;
  logic [7:0] turns;
  logic [15:0] divider;
  ert_pkg::ert_cfg_t cfg;
  logic [7:0] poles;
  logic trip;
  ert_pkg::ert_bus_req_t req;
  logic wr_pend;
  logic rd_pend;
  logic [15:0] quot;
  logic [15:0] rem;
  logic [15:0] dvd;
  logic [4:0] step;
  ert_pkg::ert_div_state_t div_state;
  logic div_start;
  logic [31:0] cpr;
  logic [31:0] cnt;
  logic [15:0] revs;
  logic [31:0] comms_pos;
  logic a_s1, a_s2, a_d, b_s1, b_s2, b_d;
  logic inc, dec;
  logic [4:0] turns_n;
  logic [5:0] st_eff;
  logic [31:0] sc_res;
  logic [31:0] rd_mux;
  logic bus_wr;

  assign turns_n = eff_turns(turns);
  assign st_eff = (st_bits == 6'h00) ? 6'h01 : st_bits;
  assign sc_res = 32'(quot) << INTERP_BITS;
  assign bus_wr = wr_pend && HSIZE_IN == 3'h2;

  // ************************************************************
  // Bus slave: writes take no wait, reads take one wait state.
  // ************************************************************
  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      req <= '0;
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
      HREADYOUT_OUT <= 1'b1;
      HRDATA_OUT <= 32'h00000000;
      HRESP_OUT <= 1'b0;
    end else begin
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
      HREADYOUT_OUT <= 1'b1;
      if (HSEL_IN && HTRANS_IN[1] && HREADY_IN) begin
        req <= '{write: HWRITE_IN, addr: HADDR_IN[7:0]};
        wr_pend <= HWRITE_IN;
        rd_pend <= !HWRITE_IN;
        HREADYOUT_OUT <= HWRITE_IN;
      end
      if (rd_pend) begin
        HRDATA_OUT <= rd_mux;
      end
    end
  end

  always_comb begin
    rd_mux = 32'h00000000;
    unique case (req.addr)
      `ERT_OFF_LINES: rd_mux = {16'h0000, lines};
      `ERT_OFF_ST_BITS: rd_mux = {26'h0000000, st_bits};
      `ERT_OFF_TURNS: rd_mux = {24'h000000, turns};
      `ERT_OFF_DIVIDER: rd_mux = {16'h0000, divider};
      `ERT_OFF_CONFIG: rd_mux = {23'h000000, cfg.linear, cfg.filter,
        3'h0, cfg.enc_type};
      `ERT_OFF_POLES: rd_mux = {24'h000000, poles};
      `ERT_OFF_STATUS: rd_mux = {20'h00000, TRIP_CODE_OUT, 7'h00, trip};
      `ERT_OFF_QUOTIENT: rd_mux = {15'h0000,
        div_state != ert_pkg::ERT_DIV_IDLE, quot};
      `ERT_OFF_SC_RES: rd_mux = sc_res;
      `ERT_OFF_POS_LO: rd_mux = POSITION_OUT[31:0];
      `ERT_OFF_POS_HI: rd_mux = {16'h0000, POSITION_OUT[47:32]};
      `ERT_OFF_TURNS_EFF: rd_mux = {27'h0000000, turns_n};
      default: rd_mux = 32'h00000000;
    endcase
  end

  // ************************************************************
  // Setup registers.
  // ************************************************************
  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      lines <= `ERT_RST_LINES;
      st_bits <= `ERT_RST_ST_BITS;
      turns <= `ERT_RST_TURNS;
      divider <= `ERT_RST_DIVIDER;
      cfg <= '0;
      poles <= `ERT_RST_POLES;
    end else begin
      if (AUTO_TURNS_VALID_IN) begin
        turns <= AUTO_TURNS_IN;
      end
      if (bus_wr) begin
        unique case (req.addr)
          `ERT_OFF_LINES: lines <= HWDATA_IN[15:0];
          `ERT_OFF_ST_BITS: st_bits <= HWDATA_IN[5:0];
          `ERT_OFF_TURNS: turns <= HWDATA_IN[7:0];
          `ERT_OFF_DIVIDER: divider <= HWDATA_IN[15:0];
          `ERT_OFF_CONFIG: cfg <= '{linear: HWDATA_IN[`ERT_CFG_LINEAR_BIT],
            filter: HWDATA_IN[`ERT_CFG_FILTER_BIT],
            enc_type: ert_pkg::ert_enc_type_t'(HWDATA_IN[3:0])};
          `ERT_OFF_POLES: poles <= HWDATA_IN[7:0];
          default: ;
        endcase
      end
    end
  end

  // ************************************************************
  // Initialisation trip: set wins over the write-one clear.
  // ************************************************************
  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      trip <= 1'b0;
      TRIP_OUT <= 1'b0;
      TRIP_CODE_OUT <= 4'h0;
    end else begin
      if (bus_wr && req.addr == `ERT_OFF_ST_BITS &&
          HWDATA_IN[5:0] != st_bits && is_serial(cfg.enc_type)) begin
        trip <= 1'b1;
        TRIP_OUT <= 1'b1;
        TRIP_CODE_OUT <= `ERT_TRIP_INIT_FAILED;
      end else if (bus_wr && req.addr == `ERT_OFF_STATUS &&
          HWDATA_IN[`ERT_STAT_TRIP_BIT]) begin
        trip <= 1'b0;
        TRIP_OUT <= 1'b0;
        TRIP_CODE_OUT <= 4'h0;
      end
    end
  end

  // ************************************************************
  // Line divider: restoring division, one quotient bit a cycle.
  // ************************************************************
  assign div_start = bus_wr &&
    (req.addr == `ERT_OFF_LINES || req.addr == `ERT_OFF_DIVIDER);

  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      div_state <= ert_pkg::ERT_DIV_RUN;
      quot <= 16'h0000;
      rem <= 16'h0000;
      dvd <= `ERT_RST_LINES;
      step <= 5'h00;
    end else if (div_start) begin
      div_state <= ert_pkg::ERT_DIV_RUN;
      dvd <= (req.addr == `ERT_OFF_LINES) ? HWDATA_IN[15:0] : lines;
      rem <= 16'h0000;
      step <= 5'h00;
    end else begin
      unique case (div_state)
        ert_pkg::ERT_DIV_IDLE: ;
        ert_pkg::ERT_DIV_RUN: begin
          if ({rem, dvd[15]} >=
              {1'b0, ((divider == 16'h0000) ? 16'h0001 : divider)}) begin
            rem <= 16'({rem, dvd[15]} -
              {1'b0, ((divider == 16'h0000) ? 16'h0001 : divider)});
            dvd <= {dvd[14:0], 1'b1};
          end else begin
            rem <= {rem[14:0], dvd[15]};
            dvd <= {dvd[14:0], 1'b0};
          end
          step <= step + 5'h01;
          if (step == `ERT_DIV_STEPS - 5'h01) begin
            div_state <= ert_pkg::ERT_DIV_DONE;
          end
        end
        ert_pkg::ERT_DIV_DONE: begin
          quot <= dvd;
          div_state <= ert_pkg::ERT_DIV_IDLE;
        end
        default: div_state <= ert_pkg::ERT_DIV_IDLE;
      endcase
    end
  end

  // ************************************************************
  // Counts per revolution: four edges per equivalent line.
  // ************************************************************
  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      cpr <= 32'h00000004;
    end else if (cfg.linear) begin
      cpr <= 32'(({16'h0000, quot, 2'b00} * {26'h0000000, poles}) >> 1);
    end else begin
      cpr <= {14'h0000, quot, 2'b00};
    end
  end

  // ************************************************************
  // Pin synchronisers and edge decode by encoder type.
  // ************************************************************
  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      {a_s1, a_s2, a_d, b_s1, b_s2, b_d} <= 6'h00;
    end else begin
      {a_s1, a_s2, a_d} <= {ENC_A_IN, a_s1, a_s2};
      {b_s1, b_s2, b_d} <= {ENC_B_IN, b_s1, b_s2};
    end
  end

  always_comb begin
    inc = 1'b0;
    dec = 1'b0;
    unique case (cfg.enc_type)
      ert_pkg::ERT_QUADRATURE_INCREMENTAL,
      ert_pkg::ERT_SINE_COSINE_INCREMENTAL: begin
        inc = (a_s2 ^ b_d) && !(a_d ^ b_s2);
        dec = (a_d ^ b_s2) && !(a_s2 ^ b_d);
      end
      ert_pkg::ERT_FREQUENCY_DIRECTION_INCREMENTAL: begin
        inc = (a_s2 ^ a_d) && !b_s2;
        dec = (a_s2 ^ a_d) && b_s2;
      end
      ert_pkg::ERT_FORWARD_REVERSE_INCREMENTAL: begin
        inc = (a_s2 ^ a_d) && !(b_s2 ^ b_d);
        dec = (b_s2 ^ b_d) && !(a_s2 ^ a_d);
      end
      default: ;
    endcase
  end

  // ************************************************************
  // Position and revolution counting.
  // ************************************************************
  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      cnt <= 32'h00000000;
      revs <= 16'h0000;
      comms_pos <= 32'h00000000;
    end else if (is_serial(cfg.enc_type)) begin
      if (COMMS_VALID_IN) begin
        // Comms resolution is not clamped to the sine resolution.
        comms_pos <= 32'(COMMS_DATA_IN << (6'h20 - st_eff));
        revs <= 16'(COMMS_DATA_IN >> st_eff);
      end
    end else if (inc) begin
      cnt <= (cnt >= cpr - 32'h00000001) ? 32'h00000000 :
        cnt + 32'h00000001;
      if (cnt >= cpr - 32'h00000001) begin
        revs <= revs + 16'h0001;
      end
    end else if (dec) begin
      cnt <= (cnt == 32'h00000000) ? cpr - 32'h00000001 :
        cnt - 32'h00000001;
      if (cnt == 32'h00000000) begin
        revs <= revs - 16'h0001;
      end
    end
  end

  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      POSITION_OUT <= 48'h000000000000;
    end else begin
      POSITION_OUT <= {revs & turns_mask(turns_n),
        is_serial(cfg.enc_type) ? comms_pos : cnt};
    end
  end

  // ************************************************************
  // Assertions.
  // ************************************************************
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RESETN_IN);

  turns_clamp_a: assert property (turns > `ERT_MAX_TURNS |->
    turns_n == 5'h10) else $error("turns not clamped to 16");
  revs_zero_a: assert property (turns == 8'h00 ##1 turns == 8'h00
    |=> POSITION_OUT[47:32] == 16'h0000) else $error("revs not held zero");
  revs_mask_a: assert property (##1 turns == $past(turns) |=>
    (POSITION_OUT[47:32] & ~turns_mask($past(turns_n, 2))) == 16'h0000)
    else $error("revs exceed mask");
  trip_set_a: assert property (bus_wr && req.addr == `ERT_OFF_ST_BITS &&
    HWDATA_IN[5:0] != st_bits && is_serial(cfg.enc_type) |=>
    TRIP_OUT && TRIP_CODE_OUT == 4'h7) else $error("no trip on change");
  trip_incr_a: assert property (!is_serial(cfg.enc_type) &&
    !TRIP_OUT ##1 !(bus_wr && req.addr == `ERT_OFF_STATUS) |-> !TRIP_OUT)
    else $error("trip for incremental type");
  auto_turns_a: assert property (AUTO_TURNS_VALID_IN && !bus_wr |=>
    turns == $past(AUTO_TURNS_IN)) else $error("auto turns not loaded");
  div_time_a: assert property (div_start ##1 !div_start [*8] ##1
    !div_start [*8] ##1 !div_start |=> div_state == ert_pkg::ERT_DIV_IDLE &&
    quot == ((divider == 16'h0000) ? lines : lines / divider))
    else $error("divider result wrong");
  cpr_rotary_a: assert property (!cfg.linear ##1 !cfg.linear |->
    cpr == {14'h0000, $past(quot), 2'b00}) else $error("bad counts per rev");
  sc_res_a: assert property (div_state == ert_pkg::ERT_DIV_IDLE &&
    divider == 16'h0001 |-> sc_res == {6'h00, lines, 10'h000})
    else $error("sine-cosine resolution wrong");
  serial_hold_a: assert property (cfg.enc_type ==
    ert_pkg::ERT_SERIAL_ONLY && !COMMS_VALID_IN |=> $stable(revs))
    else $error("serial-only position moved without comms");
  rd_wait_a: assert property (HSEL_IN && HTRANS_IN[1] && HREADY_IN &&
    !HWRITE_IN |=> !HREADYOUT_OUT ##1 HREADYOUT_OUT)
    else $error("read wait state wrong");

  wrap_c: cover property (inc && cnt == cpr - 32'h00000001);
  trip_c: cover property (TRIP_OUT ##1 !TRIP_OUT);
  comms_c: cover property (COMMS_VALID_IN && is_serial(cfg.enc_type));
  div_c: cover property (div_state == ert_pkg::ERT_DIV_DONE);

endmodule : ert_encoder_setup

//--- ert_encoder_model.sv
`timescale 1ns/1ps
// ********
// Encoder on the far side of the feedback pins.
// ********
module ert_encoder_model (
  input wire logic clk_in,
  output logic a_out,
  output logic b_out,
  output logic valid_out,
  output logic [47:0] data_out
);
  logic [1:0] ph;

  initial begin
    ph = 2'h0;
    a_out = 1'b0;
    b_out = 1'b0;
    valid_out = 1'b0;
    data_out = 48'h0;
  end

  // Quadrature steps, A leads B when moving forward.
  task automatic step(input int n, input logic fwd);
    for (int i = 0; i < n; i++) begin
      repeat (6) @(posedge clk_in);
      ph = fwd ? ph + 2'h1 : ph - 2'h1;
      a_out <= ph[1] ^ ph[0];
      b_out <= ph[1];
    end
    repeat (6) @(posedge clk_in);
  endtask : step

  // Word holds turns above the single-turn bits; released data inverts.
  task automatic send(input logic [47:0] w);
    @(posedge clk_in);
    valid_out <= 1'b1;
    data_out <= w;
    @(posedge clk_in);
    valid_out <= 1'b0;
    data_out <= ~w;
  endtask : send
endmodule : ert_encoder_model

//--- tb.sv
`timescale 1ns/1ps
`include "ert_defs.svh"
module tb;
  logic clk, rst_n, hsel, hwrite, hready, hresp, auto_v, enc_a, enc_b, cv, trip;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [7:0] auto_t;
  logic [47:0] cdata, pos, snap;
  logic [3:0] tcode;
  int failures, cmp_count, cycles;

  ert_encoder_setup #(.INTERP_BITS(10)) dut (.CLK_IN(clk), .RESETN_IN(rst_n),
    .HSEL_IN(hsel), .HADDR_IN(haddr), .HTRANS_IN(htrans), .HWRITE_IN(hwrite),
    .HSIZE_IN(hsize), .HWDATA_IN(hwdata), .HREADY_IN(hready),
    .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hready), .HRESP_OUT(hresp),
    .ENC_A_IN(enc_a), .ENC_B_IN(enc_b), .COMMS_VALID_IN(cv),
    .COMMS_DATA_IN(cdata), .AUTO_TURNS_VALID_IN(auto_v),
    .AUTO_TURNS_IN(auto_t), .POSITION_OUT(pos), .TRIP_OUT(trip),
    .TRIP_CODE_OUT(tcode));
  ert_encoder_model enc (.clk_in(clk), .a_out(enc_a), .b_out(enc_b),
    .valid_out(cv), .data_out(cdata));

  // ********
  // Clock, watchdog and reporting.
  // ********
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic check(input string what, input logic [47:0] seen,
                       input logic [47:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // ********
  // Bus access.
  // ********
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    hsize <= 3'h2;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic rdck(input string what, input logic [7:0] a,
                      input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(what, {16'h0, rd}, {16'h0, exp});
  endtask : rdck

  task automatic wait_div();
    for (int i = 0; i < 100; i++) begin
      bus(1'b0, `ERT_OFF_QUOTIENT, 32'h0);
      if (rd[16] === 1'b0) break;
    end
  endtask : wait_div

  // ********
  // Scenarios.
  // ********
  task automatic t_regs();
    rdck("lines", `ERT_OFF_LINES, 32'h1000);
    rdck("st_bits", `ERT_OFF_ST_BITS, 32'h0);
    wait_div();
    rdck("quotient", `ERT_OFF_QUOTIENT, 32'h1000);
    rdck("sc_res", `ERT_OFF_SC_RES, 32'h0040_0000);
    rdck("unmapped", 8'h3c, 32'h0);
  endtask : t_regs

  task automatic t_div();
    wr(`ERT_OFF_LINES, 32'h3039);
    wr(`ERT_OFF_DIVIDER, 32'h64);
    wait_div();
    rdck("quotient", `ERT_OFF_QUOTIENT, 32'h7b);
    rdck("sc_res", `ERT_OFF_SC_RES, 32'h1ec00);
    wr(`ERT_OFF_DIVIDER, 32'h0);
    wait_div();
    rdck("div zero", `ERT_OFF_QUOTIENT, 32'h3039);
    wr(`ERT_OFF_LINES, 32'h2);
    wr(`ERT_OFF_DIVIDER, 32'h1);
    wait_div();
  endtask : t_div

  task automatic t_turns();
    wr(`ERT_OFF_TURNS, 32'h14);
    rdck("clamp", `ERT_OFF_TURNS_EFF, 32'h10);
    wr(`ERT_OFF_TURNS, 32'h5);
    rdck("eff", `ERT_OFF_TURNS_EFF, 32'h5);
    auto_t <= 8'h09;
    auto_v <= 1'b1;
    @(posedge clk);
    auto_v <= 1'b0;
    repeat (2) @(posedge clk);
    rdck("auto", `ERT_OFF_TURNS, 32'h9);
  endtask : t_turns

  task automatic t_quad();
    wr(`ERT_OFF_CONFIG, 32'h0);
    wr(`ERT_OFF_TURNS, 32'h10);
    repeat (4) @(posedge clk);
    snap = pos;
    enc.step(8, 1'b1);
    check("rev up", pos, {snap[47:32] + 16'h1, snap[31:0]});
    enc.step(8, 1'b0);
    check("rev down", pos, snap);
    wr(`ERT_OFF_TURNS, 32'h0);
    enc.step(8, 1'b1);
    check("held", {32'h0, pos[47:32]}, 48'h0);
    wr(`ERT_OFF_TURNS, 32'h10);
    wr(`ERT_OFF_POLES, 32'h4);
    wr(`ERT_OFF_CONFIG, 32'h100);
    repeat (4) @(posedge clk);
    snap = pos;
    enc.step(8, 1'b1);
    check("lin half", pos, {snap[47:32], snap[31:0] + 32'h8});
    enc.step(8, 1'b1);
    check("lin rev", pos, {snap[47:32] + 16'h1, snap[31:0]});
  endtask : t_quad

  task automatic t_trip();
    wr(`ERT_OFF_CONFIG, 32'h0);
    wr(`ERT_OFF_ST_BITS, 32'h3);
    repeat (3) @(posedge clk);
    check("no trip", {44'h0, trip, tcode[2:0]}, 48'h0);
    wr(`ERT_OFF_CONFIG, 32'h4);
    wr(`ERT_OFF_ST_BITS, 32'hc);
    repeat (2) @(posedge clk);
    check("trip", {43'h0, trip, tcode}, {43'h1, `ERT_TRIP_INIT_FAILED});
    rdck("status", `ERT_OFF_STATUS, 32'h701);
    wr(`ERT_OFF_STATUS, 32'h1);
    wr(`ERT_OFF_ST_BITS, 32'hc);
    repeat (2) @(posedge clk);
    check("same value", {47'h0, trip}, 48'h0);
  endtask : t_trip

  task automatic t_serial();
    wr(`ERT_OFF_CONFIG, 32'h5);
    wr(`ERT_OFF_TURNS, 32'h5);
    enc.send(48'h3f_abc);
    repeat (4) @(posedge clk);
    check("serial", pos, {16'h1f, 32'habc0_0000});
    wr(`ERT_OFF_LINES, 32'h7);
    enc.send(48'h3f_abc);
    repeat (4) @(posedge clk);
    check("lines ignored", pos, {16'h1f, 32'habc0_0000});
    wr(`ERT_OFF_TURNS, 32'h0);
    enc.send(48'h3f_abc);
    repeat (4) @(posedge clk);
    check("zero turns", pos, {16'h0, 32'habc0_0000});
    wr(`ERT_OFF_TURNS, 32'h20);
    enc.send(48'h1234_5abc);
    repeat (4) @(posedge clk);
    check("wide turns", pos, {16'h2345, 32'habc0_0000});
  endtask : t_serial

  initial begin
    rst_n = 1'b0;
    hsel = 1'b0;
    htrans = 2'h0;
    haddr = 32'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    auto_v = 1'b0;
    auto_t = 8'h0;
    failures = 0;
    cmp_count = 0;
    cycles = 0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_regs();
    t_div();
    t_turns();
    t_quad();
    t_trip();
    t_serial();
    tally_and_finish();
  end
endmodule : tb
